// >>> shared/pad_pkg.sv
// Shared constants, state types and helper functions for the PCI
// address-phase encoder/decoder.
// Assumes every user runs on the PCI clock and names items with pad_pkg::.

package pad_pkg;

	// Bus command codes carried on the command lines in the address phase
	localparam logic [3:0] CMD_IO_RD   = 4'h2;
	localparam logic [3:0] CMD_IO_WR   = 4'h3;
	localparam logic [3:0] CMD_MEM_RD  = 4'h6;
	localparam logic [3:0] CMD_MEM_WR  = 4'h7;
	localparam logic [3:0] CMD_CFG_RD  = 4'hA;
	localparam logic [3:0] CMD_CFG_WR  = 4'hB;
	localparam logic [3:0] CMD_MEM_RDM = 4'hC;
	localparam logic [3:0] CMD_MEM_RDL = 4'hE;
	localparam logic [3:0] CMD_MEM_WRI = 4'hF;

	// Low address bit encodings
	localparam logic [1:0] BURST_LINEAR = 2'h0;
	localparam logic [1:0] BURST_WRAP   = 2'h2;
	localparam logic [1:0] CFG_TYPE0    = 2'h0;
	localparam logic [1:0] CFG_TYPE1    = 2'h1;

	// Configuration address field positions
	localparam int CFG_DW_LSB  = 2;
	localparam int CFG_FN_LSB  = 8;
	localparam int CFG_DEV_LSB = 11;
	localparam int CFG_BUS_LSB = 16;
	localparam int CFG_TOP_LSB = 24;

	// Device-select lines taken from the upper address lines
	localparam int         IDSEL_LSB   = 11;
	localparam logic [4:0] IDSEL_LINES = 5'h15;

	// Address step per completed data phase, in bytes
	localparam logic [31:0] ADDR_STEP = 32'h0000_0004;

	// Medium decode: claim two clocks after the address phase
	localparam logic [1:0] DEVSEL_DELAY = 2'h2;

	// Values after reset
	localparam logic [31:0] AD_RST  = 32'h0000_0000;
	localparam logic [3:0]  CBE_RST = 4'h0;

	// Arbiter and target state machines
	typedef enum logic [1:0] {
		ARB_IDLE = 2'b01,
		ARB_BUSY = 2'b10
	} pad_arb_st_t;

	typedef enum logic [2:0] {
		TGT_IDLE  = 3'b001,
		TGT_WAIT  = 3'b010,
		TGT_CLAIM = 3'b100
	} pad_tgt_st_t;

	// Memory-space command test
	function automatic logic is_mem(input logic [3:0] cmd);
		is_mem = (cmd == CMD_MEM_RD) || (cmd == CMD_MEM_WR) || (cmd == CMD_MEM_RDM)
			|| (cmd == CMD_MEM_RDL) || (cmd == CMD_MEM_WRI);
	endfunction

	// I/O-space command test
	function automatic logic is_io(input logic [3:0] cmd);
		is_io = (cmd == CMD_IO_RD) || (cmd == CMD_IO_WR);
	endfunction

	// Configuration-space command test
	function automatic logic is_cfg(input logic [3:0] cmd);
		is_cfg = (cmd == CMD_CFG_RD) || (cmd == CMD_CFG_WR);
	endfunction

	// Even parity over the full address and command, low bits included
	function automatic logic par_of(input logic [31:0] ad, input logic [3:0] cbe);
		par_of = ^{ad, cbe};
	endfunction

endpackage

// >>> core/pad_arb.sv
// Fixed-priority arbiter for the three internal initiator sources.
// Assumes requests hold until served and done pulses once per transaction.
`timescale 1ns/1ps
`default_nettype none

module pad_arb (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// Requests: bit 0 system bus, bit 1 transmit, bit 2 receive
	input  wire logic [2:0] req_i,
	input  wire logic       done_i,
	// One-hot owner
	output logic      [2:0] grant_o
);

	pad_pkg::pad_arb_st_t st_q;   // Arbiter state
	logic [2:0]           gnt_q;  // Current owner

	// Owner is held until its transaction completes, never preempted
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_q  <= pad_pkg::ARB_IDLE;
			gnt_q <= 3'h0;
		end else begin
			case (st_q)
				pad_pkg::ARB_IDLE: begin
					// Lowest index wins
					if (req_i[0]) begin
						gnt_q <= 3'h1;
						st_q  <= pad_pkg::ARB_BUSY;
					end else if (req_i[1]) begin
						gnt_q <= 3'h2;
						st_q  <= pad_pkg::ARB_BUSY;
					end else if (req_i[2]) begin
						gnt_q <= 3'h4;
						st_q  <= pad_pkg::ARB_BUSY;
					end
				end
				pad_pkg::ARB_BUSY: begin
					// Re-evaluate only after the owner finishes
					if (done_i) begin
						gnt_q <= 3'h0;
						st_q  <= pad_pkg::ARB_IDLE;
					end
				end
				default: begin
					gnt_q <= 3'h0;
					st_q  <= pad_pkg::ARB_IDLE;
				end
			endcase
		end
	end

	assign grant_o = gnt_q;

endmodule
`default_nettype wire

// >>> core/pad_core.sv
// Address-phase encoder (initiator) and decoder (target) for a PCI
// controller, plus internal initiator selection and header access.
// Assumes all bus pins are synchronous to the PCI clock CLK_I.
//
// What this block does
// - Memory low bits: 00 linear, 10 wrap.
// - Linear address steps four bytes per phase.
// - Parity always covers both low address bits.
// - Wrapped internal burst drives wrap order.
// - Single and non-wrap bursts drive 00.
// - Wrap with zero line size: one beat.
// - I/O address uses all 32 lines.
// - I/O bytes outside range: target-abort.
// - I/O low bits match lowest enabled lane.
// - Config low bits: 00 Type 0, 01 Type 1.
// - Type 0 stays local or master-aborts.
// - Type 0: function, doubleword, select needed.
// - Type 1 fields: dword, fn, dev, bus.
// - Ignore select on Type 1; answer Type 0.
// - Claim only assigned ranges, never subtractively.
// - Priority: system bus, transmit, then receive.
// - Header access needs no bus arbitration.
// - Drive config address and command together.
// - Claim two clocks after address phase.
`timescale 1ns/1ps
`default_nettype none

module pad_core (
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        NRST_I,
	// Bus lines as seen by the target
	input  wire logic [31:0] AD_I,
	input  wire logic [3:0]  CBE_I,
	input  wire logic        PAR_I,
	input  wire logic        FRAME_N_I,
	input  wire logic        IRDY_N_I,
	input  wire logic        TRDY_N_I,
	input  wire logic        IDSEL_I,
	// Assigned target ranges
	input  wire logic [31:0] MEM_BASE_I,
	input  wire logic [31:0] MEM_MASK_I,
	input  wire logic [31:0] IO_BASE_I,
	input  wire logic [31:0] IO_LIMIT_I,
	input  wire logic [7:0]  CACHE_LINE_I,
	// Target decode results
	output logic             DEVSEL_O,
	output logic [31:0]      TGT_ADDR_O,
	output logic [3:0]       TGT_CMD_O,
	output logic             TGT_ABORT_O,
	output logic             TGT_STOP_O,
	output logic             ADDR_PERR_O,
	// Internal initiator sources
	input  wire logic        XLB_REQ_I,
	input  wire logic [3:0]  XLB_CMD_I,
	input  wire logic [31:0] XLB_ADDR_I,
	input  wire logic        XLB_WRAP_I,
	input  wire logic        XLB_SINGLE_I,
	input  wire logic        TX_REQ_I,
	input  wire logic [31:0] TX_ADDR_I,
	input  wire logic        RX_REQ_I,
	input  wire logic [31:0] RX_ADDR_I,
	input  wire logic [7:0]  LOCAL_BUS_I,
	input  wire logic        BUS_GNT_I,
	input  wire logic        INIT_DONE_I,
	output logic [2:0]       GRANT_O,
	// Initiator address phase drive
	output logic [31:0]      AD_O,
	output logic             AD_OE_O,
	output logic [3:0]       CBE_O,
	output logic             CBE_OE_O,
	output logic             PAR_O,
	output logic             PAR_OE_O,
	// Internal header access
	input  wire logic        HDR_REQ_I,
	output logic             HDR_ACK_O
);

	// I/O byte enables agree with the low address bits
	function automatic logic be_ok(input logic [1:0] lo, input logic [3:0] be);
		be_ok = 1'b1;
		if (be != 4'hF) begin
			case (lo)
				2'h0: be_ok = (be[0] == 1'b0);
				2'h1: be_ok = (be[1:0] == 2'h1);
				2'h2: be_ok = (be[2:0] == 3'h3);
				default: be_ok = (be == 4'h7);
			endcase
		end
	endfunction

	// Highest enabled lane, for the range check of the last byte
	function automatic logic [1:0] hi_lane(input logic [3:0] be);
		if (!be[3])
			hi_lane = 2'h3;
		else if (!be[2])
			hi_lane = 2'h2;
		else if (!be[1])
			hi_lane = 2'h1;
		else
			hi_lane = 2'h0;
	endfunction

	// ---------------- Target side ----------------

	pad_pkg::pad_tgt_st_t st_q;        // Target state
	logic                 frame_n_q;   // Previous FRAME level
	logic                 irdy_n_q;    // Previous IRDY level
	logic                 addr_ph;     // Address phase this clock
	logic                 mem_hit;     // Memory range hit
	logic                 io_hit;      // I/O range hit
	logic                 cfg_hit;     // Type 0 config with select
	logic                 addr_hit;    // Any positive hit
	logic                 is_io_q;     // Claimed access is I/O
	logic                 resv_q;      // Reserved burst order seen
	logic [1:0]           dly_q;       // Claim delay counter
	logic                 hit_q;       // Hit held during the delay
	logic [31:0]          lat_ad_q;    // Address as sampled
	logic [3:0]           lat_cbe_q;   // Command as sampled
	logic                 chk_par_q;   // Parity due next clock
	logic                 beat_done;   // Data phase completes
	logic                 bus_end;     // Bus back to idle
	logic                 io_bad;      // I/O access cannot complete

	// Start of a transaction from an idle bus, not our own drive
	assign addr_ph = !FRAME_N_I && frame_n_q && irdy_n_q && !AD_OE_O;

	// Positive decode only; a miss is never claimed
	assign mem_hit = pad_pkg::is_mem(CBE_I)
		&& ((AD_I & MEM_MASK_I) == (MEM_BASE_I & MEM_MASK_I));
	assign io_hit = pad_pkg::is_io(CBE_I)
		&& (AD_I >= IO_BASE_I) && (AD_I <= IO_LIMIT_I);
	// Type 1 never claimed, select ignored for it
	assign cfg_hit = pad_pkg::is_cfg(CBE_I)
		&& (AD_I[1:0] == pad_pkg::CFG_TYPE0) && IDSEL_I;
	assign addr_hit = mem_hit || io_hit || cfg_hit;

	assign beat_done = (st_q == pad_pkg::TGT_CLAIM) && !IRDY_N_I && !TRDY_N_I;
	assign bus_end   = FRAME_N_I && IRDY_N_I;

	// Byte enables are valid in the first data phase (the wait clock)
	assign io_bad = !be_ok(lat_ad_q[1:0], CBE_I)
		|| ({lat_ad_q[31:2], hi_lane(CBE_I)} > IO_LIMIT_I);

	// Previous bus levels for idle detection
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			frame_n_q <= 1'b1;
			irdy_n_q  <= 1'b1;
		end else begin
			frame_n_q <= FRAME_N_I;
			irdy_n_q  <= IRDY_N_I;
		end
	end

	// Address latch and address parity check one clock later
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			lat_ad_q    <= pad_pkg::AD_RST;
			lat_cbe_q   <= pad_pkg::CBE_RST;
			chk_par_q   <= 1'b0;
			ADDR_PERR_O <= 1'b0;
		end else begin
			chk_par_q <= addr_ph;
			if (addr_ph) begin
				lat_ad_q  <= AD_I;
				lat_cbe_q <= CBE_I;
			end
			// Low two bits count even when unused for the address
			ADDR_PERR_O <= chk_par_q
				&& (PAR_I != pad_pkg::par_of(lat_ad_q, lat_cbe_q));
		end
	end

	// Target state machine: medium decode, claim, run, release
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			st_q        <= pad_pkg::TGT_IDLE;
			dly_q       <= 2'h0;
			hit_q       <= 1'b0;
			is_io_q     <= 1'b0;
			resv_q      <= 1'b0;
			DEVSEL_O    <= 1'b0;
			TGT_ABORT_O <= 1'b0;
			TGT_STOP_O  <= 1'b0;
			TGT_CMD_O   <= pad_pkg::CBE_RST;
		end else begin
			case (st_q)
				pad_pkg::TGT_IDLE: begin
					if (addr_ph) begin
						st_q      <= pad_pkg::TGT_WAIT;
						dly_q     <= 2'h1;
						hit_q     <= addr_hit;
						is_io_q   <= io_hit;
						TGT_CMD_O <= CBE_I;
						// Zero line size makes wrap reserved, as are 01 and 11
						resv_q <= mem_hit && (AD_I[1:0] != pad_pkg::BURST_LINEAR)
							&& ((AD_I[1:0] != pad_pkg::BURST_WRAP)
							|| (CACHE_LINE_I == 8'h00));
					end
				end
				pad_pkg::TGT_WAIT: begin
					// Claim lands two clocks after the address phase
					if (dly_q == pad_pkg::DEVSEL_DELAY - 2'h1) begin
						if (hit_q) begin
							st_q        <= pad_pkg::TGT_CLAIM;
							DEVSEL_O    <= 1'b1;
							TGT_ABORT_O <= is_io_q && io_bad;
						end else begin
							st_q <= pad_pkg::TGT_IDLE;
						end
					end else begin
						dly_q <= dly_q + 2'h1;
					end
				end
				pad_pkg::TGT_CLAIM: begin
					if (bus_end) begin
						st_q        <= pad_pkg::TGT_IDLE;
						DEVSEL_O    <= 1'b0;
						TGT_ABORT_O <= 1'b0;
						TGT_STOP_O  <= 1'b0;
						resv_q      <= 1'b0;
					end else if (beat_done && resv_q) begin
						// First beat given; second phase disconnects without data
						TGT_STOP_O <= 1'b1;
					end
				end
				default: begin
					st_q     <= pad_pkg::TGT_IDLE;
					DEVSEL_O <= 1'b0;
				end
			endcase
		end
	end

	// Current target address: memory from bits 31..2, I/O byte exact
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			TGT_ADDR_O <= pad_pkg::AD_RST;
		end else if (addr_ph) begin
			if (pad_pkg::is_mem(CBE_I))
				TGT_ADDR_O <= {AD_I[31:2], 2'h0};
			else
				TGT_ADDR_O <= AD_I;
		end else if (beat_done && !is_io_q) begin
			TGT_ADDR_O <= TGT_ADDR_O + pad_pkg::ADDR_STEP;
		end
	end

	// ---------------- Initiator side ----------------

	logic [31:0] ini_ad;      // Formatted address for the owner
	logic [3:0]  ini_cmd;     // Command for the owner
	logic [20:0] idsel_vec;   // One-hot device select lines
	logic [4:0]  cfg_dev;     // Device field of the request
	logic        started_q;   // Address phase already driven
	logic        go;          // Drive address phase this clock

	pad_arb u_arb (
		.clk_i  (CLK_I),
		.nrst_i (NRST_I),
		.req_i  ({RX_REQ_I, TX_REQ_I, XLB_REQ_I}),
		.done_i (INIT_DONE_I),
		.grant_o(GRANT_O)
	);

	assign cfg_dev = XLB_ADDR_I[pad_pkg::CFG_DEV_LSB +: 5];
	// Devices beyond the select lines get none and master-abort
	assign idsel_vec = (cfg_dev < pad_pkg::IDSEL_LINES)
		? (21'h0_0001 << cfg_dev) : 21'h0_0000;

	// Address and command formatting for whichever source owns the bus
	always_comb begin
		ini_ad  = pad_pkg::AD_RST;
		ini_cmd = pad_pkg::CBE_RST;
		if (GRANT_O[0]) begin
			ini_cmd = XLB_CMD_I;
			if (pad_pkg::is_mem(XLB_CMD_I)) begin
				if (XLB_WRAP_I && !XLB_SINGLE_I)
					ini_ad = {XLB_ADDR_I[31:2], pad_pkg::BURST_WRAP};
				else
					ini_ad = {XLB_ADDR_I[31:2], pad_pkg::BURST_LINEAR};
			end else if (pad_pkg::is_cfg(XLB_CMD_I)) begin
				if (XLB_ADDR_I[pad_pkg::CFG_BUS_LSB +: 8] == LOCAL_BUS_I)
					ini_ad = {idsel_vec, XLB_ADDR_I[pad_pkg::CFG_DW_LSB +: 9],
						pad_pkg::CFG_TYPE0};
				else
					ini_ad = {8'h00, XLB_ADDR_I[pad_pkg::CFG_DW_LSB +: 22],
						pad_pkg::CFG_TYPE1};
			end else begin
				ini_ad = XLB_ADDR_I;
			end
		end else if (GRANT_O[1]) begin
			ini_cmd = pad_pkg::CMD_MEM_WR;
			ini_ad  = {TX_ADDR_I[31:2], pad_pkg::BURST_LINEAR};
		end else if (GRANT_O[2]) begin
			ini_cmd = pad_pkg::CMD_MEM_RD;
			ini_ad  = {RX_ADDR_I[31:2], pad_pkg::BURST_LINEAR};
		end
	end

	// One address phase per ownership
	assign go = (GRANT_O != 3'h0) && BUS_GNT_I && !started_q && !INIT_DONE_I;

	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I)
			started_q <= 1'b0;
		else if (INIT_DONE_I)
			started_q <= 1'b0;
		else if (go)
			started_q <= 1'b1;
	end

	// Address and command lines driven together for one clock
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			AD_O     <= pad_pkg::AD_RST;
			AD_OE_O  <= 1'b0;
			CBE_O    <= pad_pkg::CBE_RST;
			CBE_OE_O <= 1'b0;
		end else begin
			AD_OE_O  <= go;
			CBE_OE_O <= go;
			if (go) begin
				AD_O  <= ini_ad;
				CBE_O <= ini_cmd;
			end
		end
	end

	// Parity trails the address by one clock and covers all 36 lines
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			PAR_O    <= 1'b0;
			PAR_OE_O <= 1'b0;
		end else begin
			PAR_OE_O <= AD_OE_O;
			PAR_O    <= pad_pkg::par_of(AD_O, CBE_O);
		end
	end

	// Header access bypasses arbitration and posted data entirely
	always_ff @(posedge CLK_I or negedge NRST_I) begin
		if (!NRST_I)
			HDR_ACK_O <= 1'b0;
		else
			HDR_ACK_O <= HDR_REQ_I && !HDR_ACK_O;
	end

	// ---------------- Checks ----------------

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!NRST_I);

	chk_claim_delay: assert property (addr_ph && addr_hit |-> ##2 DEVSEL_O)
		else $error("claim not two clocks after address phase");
	chk_miss_quiet: assert property (addr_ph && !addr_hit
		|-> ##1 !DEVSEL_O ##1 !DEVSEL_O)
		else $error("claimed an address outside all ranges");
	chk_type1_ignored: assert property (addr_ph && pad_pkg::is_cfg(CBE_I)
		&& (AD_I[1:0] == pad_pkg::CFG_TYPE1) |-> ##2 !DEVSEL_O)
		else $error("type 1 configuration access claimed");
	chk_linear_step: assert property (beat_done && !bus_end && !is_io_q
		|=> TGT_ADDR_O == $past(TGT_ADDR_O) + pad_pkg::ADDR_STEP)
		else $error("linear address did not advance by four");
	chk_wrap_drive: assert property (go && GRANT_O[0] && pad_pkg::is_mem(XLB_CMD_I)
		&& XLB_WRAP_I && !XLB_SINGLE_I |=> AD_O[1:0] == pad_pkg::BURST_WRAP)
		else $error("wrapped burst without wrap order");
	chk_single_zero: assert property (go && GRANT_O[0] && pad_pkg::is_mem(XLB_CMD_I)
		&& XLB_SINGLE_I |=> AD_O[1:0] == pad_pkg::BURST_LINEAR)
		else $error("single beat low bits not zero");
	chk_par_follow: assert property (AD_OE_O |=> PAR_OE_O
		&& (PAR_O == ^{$past(AD_O), $past(CBE_O)}))
		else $error("address parity wrong");
	chk_arb_top: assert property (GRANT_O == 3'h0 && XLB_REQ_I
		|=> GRANT_O == 3'h1)
		else $error("system bus source not preferred");
	chk_no_preempt: assert property (GRANT_O != 3'h0 && !INIT_DONE_I
		|=> GRANT_O == $past(GRANT_O))
		else $error("owner changed mid-transaction");
	chk_hdr_ack: assert property (HDR_REQ_I && !HDR_ACK_O |=> HDR_ACK_O)
		else $error("header access not acknowledged");
	chk_type1_fmt: assert property (AD_OE_O && pad_pkg::is_cfg(CBE_O)
		&& AD_O[1:0] == pad_pkg::CFG_TYPE1 |-> AD_O[31:24] == 8'h00)
		else $error("type 1 upper bits not zero");

	cov_mem_claim: cover property (addr_ph && mem_hit ##2 DEVSEL_O);
	cov_io_abort: cover property (TGT_ABORT_O);
	cov_resv_stop: cover property (TGT_STOP_O);
	cov_cfg_drive: cover property (AD_OE_O && pad_pkg::is_cfg(CBE_O));

endmodule
`default_nettype wire

// >>> bench/pad_agent.sv
// Behavioural PCI initiator that drives the target side of pad_core.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none

module pad_agent #(
	parameter int SLOT = 3 // Device line our select is wired to
) (
	// Clock
	input  wire logic        clk_i,
	// Bus lines towards the target
	output logic [31:0]      ad_o,
	output logic [3:0]       cbe_o,
	output logic             par_o,
	output logic             frame_n_o,
	output logic             irdy_n_o,
	output logic             trdy_n_o,
	output logic             idsel_o
);
	// Select taken from an upper address line, meaningful only in the address phase
	assign idsel_o = ad_o[pad_pkg::IDSEL_LSB + SLOT];

	// Idle bus at time zero
	initial begin
		ad_o = 32'h0000_0000;
		cbe_o = 4'h0;
		par_o = 1'b0;
		frame_n_o = 1'b1;
		irdy_n_o = 1'b1;
		trdy_n_o = 1'b1;
	end

	// Address phase, then first data phase with enables and parity
	task automatic addr_phase(input logic [3:0] cmd, input logic [31:0] adr,
		input logic [3:0] be, input logic bad);
		frame_n_o = 1'b0;
		ad_o = adr;
		cbe_o = cmd;
		@(posedge clk_i);
		#1;
		// Turnaround: lines no longer hold the address
		ad_o = ~adr;
		cbe_o = be;
		par_o = ^{adr, cmd} ^ bad;
		irdy_n_o = 1'b0;
	endtask

	// One completed data phase; the last one drops the frame
	task automatic beat(input logic last);
		trdy_n_o = 1'b0;
		frame_n_o = last;
		@(posedge clk_i);
		#1;
		ad_o = ~ad_o;
	endtask

	// Release the bus; released lines keep changing so no stale value is seen
	task automatic idle();
		frame_n_o = 1'b1;
		irdy_n_o = 1'b1;
		trdy_n_o = 1'b1;
		cbe_o = ~cbe_o;
		ad_o = ~ad_o;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
endmodule
`default_nettype wire

// >>> bench/test_pad_core.sv
// Self-checking bench for pad_core: target decode through pad_agent,
// initiator encoding, arbitration and header access driven directly.
// Assumes pad_pkg and pad_agent are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_pad_core;
	localparam int SLOT = 3; // Device line wired to our select
	// Stimulus
	logic        clk, nrst, par, frame_n, irdy_n, trdy_n, idsel;
	logic [31:0] ad, mem_base, mem_mask, io_base, io_limit, xlb_addr, tx_addr, rx_addr;
	logic [3:0]  cbe, xlb_cmd;
	logic [7:0]  cache_line, local_bus, bus;
	logic        xlb_req, xlb_wrap, xlb_single, tx_req, rx_req, bus_gnt, init_done, hdr_req;
	// Design outputs
	logic        devsel, tgt_abort, tgt_stop, addr_perr, ad_oe, cbe_oe, par_out, par_oe, hdr_ack;
	logic [31:0] tgt_addr, ad_out, exp;
	logic [3:0]  tgt_cmd, cbe_out;
	logic [2:0]  grant, fn;
	logic [4:0]  dev;
	logic [5:0]  dw;
	int          mismatches, total_checks, cycles, i;

	pad_core pad_core_inst (.CLK_I(clk), .NRST_I(nrst), .AD_I(ad), .CBE_I(cbe), .PAR_I(par),
		.FRAME_N_I(frame_n), .IRDY_N_I(irdy_n), .TRDY_N_I(trdy_n), .IDSEL_I(idsel),
		.MEM_BASE_I(mem_base), .MEM_MASK_I(mem_mask), .IO_BASE_I(io_base),
		.IO_LIMIT_I(io_limit), .CACHE_LINE_I(cache_line), .DEVSEL_O(devsel),
		.TGT_ADDR_O(tgt_addr), .TGT_CMD_O(tgt_cmd), .TGT_ABORT_O(tgt_abort),
		.TGT_STOP_O(tgt_stop), .ADDR_PERR_O(addr_perr), .XLB_REQ_I(xlb_req),
		.XLB_CMD_I(xlb_cmd), .XLB_ADDR_I(xlb_addr), .XLB_WRAP_I(xlb_wrap),
		.XLB_SINGLE_I(xlb_single), .TX_REQ_I(tx_req), .TX_ADDR_I(tx_addr), .RX_REQ_I(rx_req),
		.RX_ADDR_I(rx_addr), .LOCAL_BUS_I(local_bus), .BUS_GNT_I(bus_gnt),
		.INIT_DONE_I(init_done), .GRANT_O(grant), .AD_O(ad_out), .AD_OE_O(ad_oe),
		.CBE_O(cbe_out), .CBE_OE_O(cbe_oe), .PAR_O(par_out), .PAR_OE_O(par_oe),
		.HDR_REQ_I(hdr_req), .HDR_ACK_O(hdr_ack));

	pad_agent #(.SLOT(SLOT)) pad_agent_inst (.clk_i(clk), .ad_o(ad), .cbe_o(cbe), .par_o(par),
		.frame_n_o(frame_n), .irdy_n_o(irdy_n), .trdy_n_o(trdy_n), .idsel_o(idsel));

	// Free-running clock, 10 ns period
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Hang guard: the whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			report_and_stop();
		end
	end

	// Inputs change 1 ns after the edge so sampling never races
	task automatic tick();
		@(posedge clk);
		#1;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			mismatches++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, want);
		end
	endtask

	task automatic report_and_stop();
		if (mismatches == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One target transaction of two beats, judged against a reference decode
	task automatic tgt(input logic [3:0] cmd, input logic [31:0] adr, input logic [3:0] be,
		input logic bad);
		int k;
		logic hit, abt, stp, mem;
		logic [31:0] ta;
		mem = cmd inside {pad_pkg::CMD_MEM_RD, pad_pkg::CMD_MEM_WR, pad_pkg::CMD_MEM_RDL};
		abt = 1'b0;
		stp = 1'b0;
		ta = adr;
		if (mem) begin
			hit = (adr & mem_mask) == (mem_base & mem_mask);
			// Reserved orders, and wrap without a line size, disconnect after one beat
			stp = hit && adr[1:0] != 2'b00 && !(adr[1:0] == 2'b10 && cache_line != 8'h00);
			ta = {adr[31:2], 2'b00};
		end else if (cmd[3:1] == 3'h1) begin
			hit = adr >= io_base && adr <= io_limit;
			for (k = 0; k < 4; k++)
				if (!be[k] && {adr[31:2], 2'b00} + 32'(k) > io_limit)
					abt = hit;
			// Lowest enabled lane must sit at the address offset
			if (be != 4'hF && (be[adr[1:0]] || (be | (4'hF << adr[1:0])) != 4'hF))
				abt = hit;
		end else
			hit = adr[1:0] == 2'b00 && adr[pad_pkg::IDSEL_LSB + SLOT];
		pad_agent_inst.addr_phase(cmd, adr, be, bad);
		check(devsel, 1'b0);
		tick();
		check(devsel, hit);
		check(addr_perr, bad);
		check(tgt_abort, abt);
		if (hit)
			check(tgt_addr, ta);
		if (hit)
			check(tgt_cmd, cmd);
		pad_agent_inst.beat(1'b0);
		check(tgt_stop, stp);
		if (hit && mem)
			check(tgt_addr, ta + pad_pkg::ADDR_STEP);
		pad_agent_inst.beat(1'b1);
		pad_agent_inst.idle();
		check(devsel, 1'b0);
	endtask

	// Serve one granted source: one address phase, then completion
	task automatic serve(input logic [2:0] g, input logic [31:0] ad_x, input logic [3:0] cmd);
		int n;
		for (n = 0; n < 20 && grant === 3'b000; n++)
			tick();
		check(grant, g);
		for (n = 0; n < 20 && ad_oe !== 1'b1; n++)
			tick();
		check(ad_out, ad_x);
		check({ad_oe, cbe_oe, cbe_out}, {2'b11, cmd});
		tick();
		check({ad_oe, par_oe, par_out}, {2'b01, ^{ad_x, cmd}});
		{rx_req, tx_req, xlb_req} = {rx_req, tx_req, xlb_req} & ~g;
		init_done = 1'b1;
		tick();
		init_done = 1'b0;
		check(grant, 3'b000);
	endtask

	initial begin
		void'($urandom(32'h2c81));
		nrst = 1'b0;
		mem_base = 32'h4000_0000;
		mem_mask = 32'hF000_0000;
		io_base = 32'h0000_1000;
		io_limit = 32'h0000_10FE;
		cache_line = 8'h00;
		local_bus = 8'($urandom);
		{xlb_req, xlb_wrap, xlb_single, tx_req, rx_req, bus_gnt, init_done, hdr_req} = 8'h00;
		xlb_cmd = pad_pkg::CMD_MEM_RD;
		xlb_addr = $urandom;
		tx_addr = $urandom;
		rx_addr = $urandom;
		repeat (8) @(posedge clk);
		#1;
		nrst = 1'b1;
		check({grant, devsel, ad_oe}, 5'h00);
		tick();
		tick();
		// Memory: linear hit, miss, wrap without line size, reserved, wrap with bad parity
		tgt(pad_pkg::CMD_MEM_RD, {4'h4, 26'($urandom), 2'b00}, 4'h0, 1'b0);
		tgt(pad_pkg::CMD_MEM_WR, {4'h5, 26'($urandom), 2'b00}, 4'h0, 1'b0);
		tgt(pad_pkg::CMD_MEM_RDL, {4'h4, 26'($urandom), 2'b10}, 4'h0, 1'b0);
		tgt(pad_pkg::CMD_MEM_RD, {4'h4, 26'($urandom), 2'b01}, 4'h0, 1'b0);
		cache_line = 8'h08;
		tgt(pad_pkg::CMD_MEM_RDL, {4'h4, 26'($urandom), 2'b10}, 4'h0, 1'b1);
		// I/O: one lane past the limit, all lanes inside, outside the range
		tgt(pad_pkg::CMD_IO_RD, 32'h0000_10FE, 4'h3, 1'b0);
		tgt(pad_pkg::CMD_IO_WR, 32'h0000_10FE, 4'hB, 1'b0);
		// Enabled lane below the address offset: must abort
		tgt(pad_pkg::CMD_IO_RD, 32'h0000_1041, 4'hC, 1'b0);
		tgt(pad_pkg::CMD_IO_RD, 32'h0000_2001, 4'hD, 1'b0);
		// Config: Type 0 selected, Type 0 unselected, Type 1 with select high
		tgt(pad_pkg::CMD_CFG_RD, 32'h0000_4000 | {21'h0, 3'($urandom), 6'($urandom), 2'b00},
			4'h0, 1'b0);
		tgt(pad_pkg::CMD_CFG_WR, 32'h0000_0104, 4'h0, 1'b0);
		tgt(pad_pkg::CMD_CFG_RD, 32'h0001_4105, 4'h0, 1'b0);
		// Receive owns the grant while higher sources arrive; header access meanwhile
		xlb_single = 1'b1;
		rx_req = 1'b1;
		repeat (3) tick();
		xlb_req = 1'b1;
		tx_req = 1'b1;
		repeat (3) tick();
		check(grant, 3'b100);
		hdr_req = 1'b1;
		tick();
		check(hdr_ack, 1'b1);
		hdr_req = 1'b0;
		tick();
		check(hdr_ack, 1'b0);
		bus_gnt = 1'b1;
		serve(3'b100, {rx_addr[31:2], 2'b00}, pad_pkg::CMD_MEM_RD);
		serve(3'b001, {xlb_addr[31:2], 2'b00}, pad_pkg::CMD_MEM_RD);
		serve(3'b010, {tx_addr[31:2], 2'b00}, pad_pkg::CMD_MEM_WR);
		// System bus encodings: wrapped, single, local config, remote config
		for (i = 0; i < 4; i++) begin
			dev = 5'($urandom % 21);
			fn = 3'($urandom);
			dw = 6'($urandom);
			bus = local_bus + 8'(i == 3);
			xlb_addr = (i < 2) ? $urandom : {8'h00, bus, dev, fn, dw, 2'b00};
			xlb_cmd = (i < 2) ? pad_pkg::CMD_MEM_WR : pad_pkg::CMD_CFG_RD;
			xlb_wrap = i < 2;
			xlb_single = i == 1;
			case (i)
				0: exp = {xlb_addr[31:2], 2'b10};
				1: exp = {xlb_addr[31:2], 2'b00};
				2: exp = (32'h0000_0001 << (11 + dev)) | {21'h0, fn, dw, 2'b00};
				default: exp = {8'h00, bus, dev, fn, dw, 2'b01};
			endcase
			xlb_req = 1'b1;
			serve(3'b001, exp, xlb_cmd);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
